/* rtl/ccd_top.sv */
// cpu clock source selection, legacy halve, programmable divider, clock out
// assumes osc_tick is a one-cycle pulse per oscillator clock, synchronous to mclk
`timescale 1ns/1ps
module ccd_top #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // programmed configuration
  input  wire logic [2:0]        osc_sel_cfg,
  input  wire logic              legacy_timing_halve_cfg,
  // oscillator activity
  input  wire logic              osc_tick,
  input  wire logic              ext_clock_in_pin,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // clock enables to cpu and peripherals
  output ccd_pkg::ccd_clk_s      clk_en,
  // crystal output and input pins
  output ccd_pkg::ccd_pin_s      pins
);

  // ****************************************
  // configuration
  // ****************************************
  ccd_pkg::ccd_osc_e osc_type;
  logic              cfg_legacy;
  logic              is_xtal;
  logic              osc_edge;

  // strap captured on every clock while rst is high, held once rst falls
  always_ff @(posedge mclk) begin
    if (rst) begin
      osc_type   <= ccd_pkg::ccd_osc_e'(osc_sel_cfg);
      cfg_legacy <= legacy_timing_halve_cfg;
    end
  end

  assign is_xtal = (osc_type != ccd_pkg::CCD_OSC_RC) &&
                   (osc_type != ccd_pkg::CCD_OSC_EXT);

  // the external source may run down to static: no edge, no tick
  assign osc_edge = (osc_type == ccd_pkg::CCD_OSC_EXT) ? ext_clock_in_pin
                                                       : osc_tick;

  // ****************************************
  // registers
  // ****************************************
  logic [DIV_W-1:0] cpu_clock_divider_value;
  logic [7:0]       port2_mode_reg_one;
  logic [1:0]       pwr_ctrl;
  logic             wr_en;
  logic             rd_en;
  logic             addr_ok;

  assign addr_ok = (paddr == ccd_pkg::CCD_DIV_OFS)    ||
                   (paddr == ccd_pkg::CCD_PORT2_OFS)  ||
                   (paddr == ccd_pkg::CCD_STATUS_OFS) ||
                   (paddr == ccd_pkg::CCD_CTRL_OFS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && !penable && !pwrite;

  // divider value taken any time; the cpu keeps running
  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_clock_divider_value <= DIV_W'(ccd_pkg::CCD_DIV_RST);
    end else if (wr_en && paddr == ccd_pkg::CCD_DIV_OFS) begin
      cpu_clock_divider_value <= pwdata[DIV_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      port2_mode_reg_one <= ccd_pkg::CCD_PORT2_RST;
    end else if (wr_en && paddr == ccd_pkg::CCD_PORT2_OFS) begin
      port2_mode_reg_one <= pwdata[7:0];
    end
  end

  // ****************************************
  // power modes and wake count
  // ****************************************
  typedef enum logic [1:0] {
    CCD_RUN  = 2'b00,
    CCD_IDLE = 2'b01,
    CCD_DOWN = 2'b11,
    CCD_WAKE = 2'b10
  } ccd_pwr_e;

  ccd_pwr_e    pwr_state;
  logic [10:0] wake_cnt;
  logic        wake_req;
  logic        wake_done;

  assign wake_req  = wr_en && paddr == ccd_pkg::CCD_CTRL_OFS &&
                     pwdata[ccd_pkg::CCD_IDLE_BIT] == 1'b0 &&
                     pwdata[ccd_pkg::CCD_PD_BIT] == 1'b0;
  assign wake_done = (wake_cnt == 11'h000) && osc_edge;
  assign pwr_ctrl  = {pwr_state == CCD_DOWN, pwr_state == CCD_IDLE};

  always_ff @(posedge mclk) begin
    if (rst) begin
      pwr_state <= CCD_RUN;
      wake_cnt  <= 11'h000;
    end else begin
      unique case (pwr_state)
        CCD_RUN: begin
          if (wr_en && paddr == ccd_pkg::CCD_CTRL_OFS) begin
            if (pwdata[ccd_pkg::CCD_PD_BIT]) begin
              pwr_state <= CCD_DOWN;
            end else if (pwdata[ccd_pkg::CCD_IDLE_BIT]) begin
              pwr_state <= CCD_IDLE;
            end
          end
        end
        CCD_IDLE: begin
          if (wake_req) begin
            pwr_state <= CCD_RUN;
          end
        end
        CCD_DOWN: begin
          // oscillator restarts at once; count its clocks before running
          if (wake_req) begin
            pwr_state <= CCD_WAKE;
            wake_cnt  <= is_xtal ? 11'(ccd_pkg::CCD_XTAL_WAKE_CLKS - 1)
                                 : 11'(ccd_pkg::CCD_RC_WAKE_CLKS - 1);
          end
        end
        CCD_WAKE: begin
          if (wake_done) begin
            pwr_state <= CCD_RUN;
          end else if (osc_edge) begin
            wake_cnt <= wake_cnt - 11'h001;
          end
        end
      endcase
    end
  end

  // ****************************************
  // legacy halve, programmable divider
  // ****************************************
  logic             osc_run;
  logic             base_en;
  logic             half_tog;
  logic [9:0]       ratio_now;
  logic [9:0]       next_ratio;
  logic             cpu_tick;
  logic             div_bound;

  assign osc_run = (pwr_state != CCD_DOWN);

  always_ff @(posedge mclk) begin
    if (rst) begin
      half_tog <= 1'b0;
    end else if (osc_run && osc_edge) begin
      half_tog <= ~half_tog;
    end
  end

  // halved tick feeds cpu and peripherals alike
  assign base_en = osc_run && osc_edge && (!cfg_legacy || half_tog);

  // ratio 2*(n+1) for n>0, one for n==0
  assign next_ratio = (cpu_clock_divider_value == '0) ? 10'h001
                      : {1'b0, cpu_clock_divider_value, 1'b0} + 10'h002;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ratio_now <= 10'h001;
    end else if (div_bound) begin
      ratio_now <= next_ratio;
    end
  end

  ccd_div #(
    .W (10)
  ) u_cpu_div (
    .mclk     (mclk),
    .rst      (rst),
    .in_en    (base_en),
    .ratio    (ratio_now),
    .out_en   (cpu_tick),
    .boundary (div_bound)
  );

  // ****************************************
  // clock output at one sixth of cpu clock
  // ****************************************
  logic       clkout_ok;
  logic       clkout_bit;
  logic [2:0] six_cnt;
  logic       clkout_lvl;

  assign clkout_ok  = !is_xtal;
  assign clkout_bit = port2_mode_reg_one[ccd_pkg::CCD_CLKOUT_EN_BIT];

  // idle keeps the cpu tick running, so the output stays alive there
  always_ff @(posedge mclk) begin
    if (rst) begin
      six_cnt    <= 3'h0;
      clkout_lvl <= 1'b0;
    end else if (cpu_tick) begin
      if (six_cnt == 3'(ccd_pkg::CCD_HALF_CLKOUT - 1)) begin
        six_cnt    <= 3'h0;
        clkout_lvl <= ~clkout_lvl;
      end else begin
        six_cnt <= six_cnt + 3'h1;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_en <= '0;
      pins   <= '0;
    end else begin
      clk_en.cpu_en    <= cpu_tick && (pwr_state == CCD_RUN);
      clk_en.periph_en <= cpu_tick;
      clk_en.run       <= (pwr_state == CCD_RUN);
      pins.xo_out      <= clkout_lvl;
      pins.xo_oe       <= clkout_ok && clkout_bit && osc_run;
      pins.xo_in_ok    <= (osc_type == ccd_pkg::CCD_OSC_RC) ||
                          (osc_type == ccd_pkg::CCD_OSC_EXT);
      pins.xi_in_ok    <= (osc_type == ccd_pkg::CCD_OSC_RC);
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        ccd_pkg::CCD_DIV_OFS:    prdata <= {24'h00_0000, cpu_clock_divider_value};
        ccd_pkg::CCD_PORT2_OFS:  prdata <= {24'h00_0000, port2_mode_reg_one};
        ccd_pkg::CCD_STATUS_OFS: prdata <= {22'h00_0000, ratio_now};
        ccd_pkg::CCD_CTRL_OFS:   prdata <= {23'h00_0000, cfg_legacy, osc_type,
                                            2'b00, pwr_state, 1'b0};
        default:                 prdata <= 32'h0000_0000;
      endcase
    end
  end

  logic unused_ok;
  assign unused_ok = ^pwr_ctrl;

endmodule : ccd_top

/* shared/ccd_pkg.sv */
// package for the cpu clock source and divider block
// assumes a single mclk domain; used by rtl/ccd_top.sv and the bench, not by rtl/ccd_div.sv
package ccd_pkg;

  // ****************************************
  // oscillator selection
  // ****************************************
  typedef enum logic [2:0] {
    CCD_OSC_LF_XTAL  = 3'h0,
    CCD_OSC_MF_XTAL  = 3'h1,
    CCD_OSC_HF_XTAL  = 3'h2,
    CCD_OSC_CERAMIC  = 3'h3,
    CCD_OSC_RC       = 3'h4,
    CCD_OSC_EXT      = 3'h5
  } ccd_osc_e;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [11:0] CCD_DIV_OFS    = 12'h000;
  localparam logic [11:0] CCD_PORT2_OFS  = 12'h004;
  localparam logic [11:0] CCD_STATUS_OFS = 12'h008;
  localparam logic [11:0] CCD_CTRL_OFS   = 12'h00C;

  // port2_mode_reg_one and control register field positions
  localparam int CCD_CLKOUT_EN_BIT = 1;
  localparam int CCD_IDLE_BIT      = 0;
  localparam int CCD_PD_BIT        = 1;

  // reset values
  localparam logic [7:0]  CCD_DIV_RST   = 8'h00;
  localparam logic [7:0]  CCD_PORT2_RST = 8'h00;

  // ****************************************
  // timing counts
  // ****************************************
  localparam int CCD_XTAL_WAKE_CLKS = 1024;
  localparam int CCD_RC_WAKE_CLKS   = 256;
  localparam int CCD_CLKOUT_DIV     = 6;
  localparam int CCD_HALF_CLKOUT    = CCD_CLKOUT_DIV / 2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       cpu_en;
    logic       periph_en;
    logic       run;
  } ccd_clk_s;

  typedef struct packed {
    logic       xo_out;
    logic       xo_oe;
    logic       xo_in_ok;
    logic       xi_in_ok;
  } ccd_pin_s;

endpackage : ccd_pkg

/* rtl/ccd_div.sv */
// one rate divider: emits a one-cycle enable every ratio input enables
// assumes ratio only changes on a boundary (the parent takes care of it)
`timescale 1ns/1ps
module ccd_div #(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // rate control
  input  wire logic         in_en,
  input  wire logic [W-1:0] ratio,
  // divided enable
  output logic              out_en,
  output logic              boundary
);

  logic [W-1:0] cnt;

  // boundary means next counted input edge emits a pulse
  assign boundary = (cnt == '0);
  assign out_en   = in_en && boundary;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt <= '0;
    end else if (in_en) begin
      if (boundary) begin
        cnt <= (ratio > 1) ? ratio - W'(1) : '0;
      end else begin
        cnt <= cnt - W'(1);
      end
    end
  end

endmodule : ccd_div

/* bench/ccd_osc_model.sv */
// oscillator model: one tick every per mclk cycles, static while stop
// assumes per is 2 or more
`timescale 1ns/1ps
module ccd_osc_model (
  // control
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       stop,
  input  wire logic [3:0] per,
  input  wire logic       ext_mode,
  // source pulses
  output logic            osc_tick,
  output logic            ext_clock_in_pin
);
  logic [3:0] cnt;
  always_ff @(posedge mclk) begin
    if (rst || stop || cnt >= per - 4'h1) cnt <= 4'h0;
    else cnt <= cnt + 4'h1;
  end
  assign osc_tick = !ext_mode && !stop && cnt == 4'h0;
  // external source may sit static, down to 0 Hz
  assign ext_clock_in_pin = ext_mode && !stop && cnt == 4'h0;
endmodule : ccd_osc_model

/* bench/ccd_top_assertions.sv */
// checker bound to ccd_top: pin release, clock out pacing, enable spacing
// assumes straps only change while rst is high
`timescale 1ns/1ps
module ccd_top_chk (
  // clock and reset
  input wire logic              mclk,
  input wire logic              rst,
  // straps and sources
  input wire logic [2:0]        osc_sel_cfg,
  input wire logic              legacy_timing_halve_cfg,
  input wire logic              osc_tick,
  input wire logic              ext_clock_in_pin,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  // outputs
  input wire ccd_pkg::ccd_clk_s clk_en,
  input wire ccd_pkg::ccd_pin_s pins
);
  logic       src;
  logic       seen;
  logic       arm;
  logic [2:0] gap;
  logic [2:0] tk;
  logic [2:0] tog;
  assign src = (osc_sel_cfg == 3'h5) ? ext_clock_in_pin : osc_tick;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge mclk) begin
    if (rst || src) gap <= 3'h0;
    else if (gap != 3'h7) gap <= gap + 3'h1;
  end
  // a tick in the pulse cycle belongs to the next interval
  always_ff @(posedge mclk) begin
    if (rst || clk_en.periph_en) tk <= {2'h0, src};
    else if (src && tk != 3'h7) tk <= tk + 3'h1;
  end
  always_ff @(posedge mclk) begin
    if (rst || !pins.xo_oe || $changed(pins.xo_out)) tog <= 3'h0;
    else if (clk_en.periph_en && tog != 3'h7) tog <= tog + 3'h1;
  end
  // the first toggle after enable has an unknown phase, so it is skipped
  always_ff @(posedge mclk) begin
    seen <= !rst && (seen || clk_en.periph_en);
    arm  <= !rst && pins.xo_oe && (arm || $changed(pins.xo_out));
  end
  AST_XTAL_PINS: assert property (osc_sel_cfg < 3'h4 |-> pins[2:0] == 3'h0)
    else $error("pin active in crystal mode");
  AST_CLKOUT_MODE: assert property (pins.xo_oe |-> osc_sel_cfg inside {3'h4, 3'h5})
    else $error("clock out in crystal mode");
  // pins are still at their reset value one edge after release
  AST_EXT_PORT: assert property (osc_sel_cfg == 3'h5 && !pins.xo_oe && !$past(rst)
    |-> pins.xo_in_ok)
    else $error("pin not freed");
  AST_CLKOUT_RATE: assert property ($changed(pins.xo_out) && arm && pins.xo_oe
    |-> tog inside {[3'h2:3'h3]}) else $error("clock out early");
  AST_CLKOUT_BOUND: assert property (arm |-> tog < 3'h4)
    else $error("clock out stalled");
  AST_TICK_CAUSE: assert property (clk_en.periph_en |-> gap < 3'h4)
    else $error("enable without tick");
  AST_LEGACY_GAP: assert property (legacy_timing_halve_cfg && seen && clk_en.periph_en
    |-> tk >= 3'h2) else $error("halve missing");
  AST_DIV_WRITE: assert property (psel && penable && pwrite && paddr == 12'h000
    |-> pready && !pslverr) else $error("divider write refused");
  COV_LEGACY: cover property (legacy_timing_halve_cfg && clk_en.cpu_en);
  COV_TOGGLE: cover property (arm && $changed(pins.xo_out));
  COV_WAKE: cover property (!clk_en.run ##1 clk_en.run);
endmodule : ccd_top_chk

bind ccd_top ccd_top_chk u_chk (.mclk, .rst, .osc_sel_cfg, .legacy_timing_halve_cfg, .osc_tick,
  .ext_clock_in_pin, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .clk_en, .pins);

/* bench/ccd_top_test.sv */
// testbench for ccd_top: straps, divider, legacy halve, wake count, clock out
// assumes the oscillator model on the source pins and the bound checker
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error %0t: got %0h want %0h", $time, a, b); end end
module ccd_top_test;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic [2:0]        osc_sel_cfg = 3'h4;
  logic              legacy_timing_halve_cfg = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic              stop = 1'b0;
  logic [3:0]        per = 4'h2;
  logic              osc_tick;
  logic              ext_clock_in_pin;
  logic              pready;
  logic              pslverr;
  logic [31:0]       prdata;
  logic [31:0]       rd;
  logic              er;
  ccd_pkg::ccd_clk_s clk_en;
  ccd_pkg::ccd_pin_s pins;
  int                n_mismatch = 0;
  int                checks = 0;
  int                cyc = 0;
  int                n;
  int                n2;
  int                tab[3] = '{1, 3, 255};
  always #12.5 mclk = ~mclk;
  ccd_top #(.DIV_W(8)) dut (.mclk, .rst, .osc_sel_cfg, .legacy_timing_halve_cfg, .osc_tick,
    .ext_clock_in_pin, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .clk_en, .pins);
  ccd_osc_model u_osc (.mclk, .rst, .stop, .per, .ext_mode(osc_sel_cfg == 3'h5), .osc_tick,
    .ext_clock_in_pin);
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // straps are only moved while reset is held
  task automatic restart(input logic [2:0] sel, input logic leg);
    @(posedge mclk);
    rst                     <= 1'b1;
    osc_sel_cfg             <= sel;
    legacy_timing_halve_cfg <= leg;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
  endtask : restart
  task automatic sync_cpu;
    do @(posedge mclk); while (clk_en.cpu_en !== 1'b1);
  endtask : sync_cpu
  // window is a whole number of periods, so latency does not matter
  task automatic measure(input int ratio, input int k);
    sync_cpu;
    n = 0;
    n2 = 0;
    repeat (ratio * k * per) begin
      @(posedge mclk);
      n += (clk_en.cpu_en === 1'b1);
      n2 += (clk_en.periph_en === 1'b1);
    end
  endtask : measure
  task automatic gap;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (clk_en.cpu_en !== 1'b1 && n < 2000);
  endtask : gap
  task automatic tcount(input int cycles);
    logic last;
    last = pins.xo_out;
    n = 0;
    while (pins.xo_out === last && n < 200) begin
      @(posedge mclk);
      n++;
    end
    last = pins.xo_out;
    n = 0;
    repeat (cycles) begin
      @(posedge mclk);
      n += (pins.xo_out !== last);
      last = pins.xo_out;
    end
  endtask : tcount
  task automatic pd_wake(input int w);
    apb(1'b1, ccd_pkg::CCD_CTRL_OFS, 32'h0000_0002);
    repeat (8) @(posedge mclk);
    `CHK(clk_en.run, 1'b0)
    apb(1'b1, ccd_pkg::CCD_CTRL_OFS, 32'h0000_0000);
    n = 0;
    while (clk_en.cpu_en !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      n += (osc_tick === 1'b1);
    end
    `CHK(n >= w && n <= w + 4, 1'b1)
  endtask : pd_wake
  task automatic t_crystal;
    restart(3'h0, 1'b1);
    apb(1'b0, ccd_pkg::CCD_CTRL_OFS, 32'h0000_0000);
    `CHK(rd[8:5], 4'h8)
    `CHK(pins[2:0], 3'h0)
    apb(1'b1, ccd_pkg::CCD_PORT2_OFS, 32'h0000_0002);
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0000_0000)
    `CHK(pins.xo_oe, 1'b0)
    pd_wake(ccd_pkg::CCD_XTAL_WAKE_CLKS);
  endtask : t_crystal
  task automatic t_div;
    restart(3'h4, 1'b0);
    measure(1, 4);
    `CHK(n, 4)
    `CHK(n2, 4)
    `CHK(pins[1:0], 2'h3)
    foreach (tab[i]) begin
      apb(1'b1, ccd_pkg::CCD_DIV_OFS, 32'(tab[i]));
      measure(2 * (tab[i] + 1), 2);
      `CHK(n, 2)
      apb(1'b0, ccd_pkg::CCD_STATUS_OFS, 32'h0000_0000);
      `CHK(rd[9:0], 10'(2 * (tab[i] + 1)))
    end
    apb(1'b1, ccd_pkg::CCD_DIV_OFS, 32'h0000_0003);
    sync_cpu;
    apb(1'b1, ccd_pkg::CCD_DIV_OFS, 32'h0000_0001);
    gap;
    `CHK(n + 3, 8 * per)
    gap;
    `CHK(n, 4 * per)
  endtask : t_div
  task automatic t_legacy;
    restart(3'h4, 1'b1);
    measure(2, 4);
    `CHK(n, 4)
    `CHK(n2, 4)
    pd_wake(ccd_pkg::CCD_RC_WAKE_CLKS);
  endtask : t_legacy
  task automatic t_clkout;
    per <= 4'h3;
    restart(3'h5, 1'b0);
    apb(1'b0, ccd_pkg::CCD_CTRL_OFS, 32'h0000_0000);
    `CHK(rd[7:5], 3'h5)
    `CHK(pins.xo_in_ok, 1'b1)
    `CHK(pins.xi_in_ok, 1'b0)
    // no cpu tick can come while the source is static, so no sync here
    stop <= 1'b1;
    repeat (8) @(posedge mclk);
    n = 0;
    repeat (60) begin
      @(posedge mclk);
      n += (clk_en.periph_en === 1'b1);
    end
    `CHK(n, 0)
    stop <= 1'b0;
    apb(1'b1, ccd_pkg::CCD_PORT2_OFS, 32'h0000_0002);
    tcount(90);
    `CHK(n, 10)
    `CHK(pins.xo_oe, 1'b1)
    apb(1'b1, ccd_pkg::CCD_CTRL_OFS, 32'h0000_0001);
    tcount(90);
    `CHK(n, 10)
    apb(1'b1, ccd_pkg::CCD_PORT2_OFS, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    `CHK(pins.xo_oe, 1'b0)
  endtask : t_clkout
  initial begin
    t_crystal;
    t_div;
    t_legacy;
    t_clkout;
    print_verdict;
  end
endmodule : ccd_top_test
